/* logic/dbg_trig_pkg.sv */
package dbg_trig_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int CTRL_W = 8;
    localparam logic [ADDR_W-1:0] CTRL_OFFSET = 12'h000;
    localparam logic [ADDR_W-1:0] STATUS_OFFSET = 12'h004;
    localparam int QUAL_BIT = 7;
    localparam int BEGIN_BIT = 6;
    localparam int MODE_LSB = 0;
    localparam int MODE_W = 4;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 8'h00;
    localparam logic [CTRL_W-1:0] CTRL_WMASK = 8'hcf;
    localparam int ST_CAPTURE_BIT = 0;
    localparam int ST_A_SEEN_BIT = 1;
    localparam int ST_DONE_BIT = 2;
    localparam int ST_BEGIN_BIT = 3;
    localparam int ST_ARMED_BIT = 4;
    localparam int NUM_MATCH = 5;
    localparam int M_A = 0;
    localparam int M_B = 1;
    localparam int M_BDATA = 2;
    localparam int M_GE_A = 3;
    localparam int M_LE_B = 4;
    typedef enum logic [3:0] {
        MODE_A_ONLY = 4'b0000,
        MODE_A_OR_B = 4'b0001,
        MODE_A_THEN_B = 4'b0010,
        MODE_EV_B = 4'b0011,
        MODE_A_THEN_EV_B = 4'b0100,
        MODE_A_AND_BD = 4'b0101,
        MODE_A_ANDN_BD = 4'b0110,
        MODE_IN_RANGE = 4'b0111,
        MODE_OUT_RANGE = 4'b1000
    } trig_mode_t;
    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_WAIT_A = 2'b01,
        SEQ_WAIT_B = 2'b10,
        SEQ_DONE = 2'b11
    } seq_state_t;
endpackage : dbg_trig_pkg

/* logic/debug_trigger_select.sv */
`timescale 1ns/100ps
// Notes on behaviour
// RULE1: The trigger control register reads at any time but a write is ignored while the debug module is armed.
// RULE2: Bits 4 and 5 of the trigger control register always read as zero whatever is written.
// RULE3: With the qualify select at 0 a match counts on access, at 1 only once the opcode at that address executes.
// RULE4: With begin select at 0 capture runs circularly until a trigger ends it, at 1 a trigger starts storage.
// RULE5: Event-only modes ignore the begin select and always behave as a begin trace.
// RULE6: Mode codes 0000 to 0100 give A only, A or B, A then B, event-only B, and A then event-only B.
// RULE7: Mode code 0101 triggers on an A address match together with a B data match.
// RULE8: Codes 0110, 0111 and 1000 give A without B data, inside the A to B range, and outside it.
// RULE9: Mode codes 1001 to 1111 never produce a trigger.
// RULE10: The trigger event leaves as a one-cycle pulse on the bus clock.
module debug_trigger_select
    import dbg_trig_pkg::*;
(
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [ADDR_W-1:0] paddr_i,
    input wire logic [DATA_W-1:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic [DATA_W-1:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic armed_i,
    input wire logic access_i,
    input wire logic cmp_a_match_i,
    input wire logic cmp_b_match_i,
    input wire logic cmp_b_data_match_i,
    input wire logic addr_ge_a_i,
    input wire logic addr_le_b_i,
    input wire logic opcode_exec_i,
    output logic trigger_o,
    output logic capture_o,
    output logic begin_trace_o
);
    logic [CTRL_W-1:0] ctrl_r;
    logic [DATA_W-1:0] prdata_r;
    logic pslverr_r;
    seq_state_t state_r;
    seq_state_t state_nxt;
    logic capture_r;
    logic trigger_r;
    logic setup;
    logic wr_ctrl;
    logic sel_ctrl;
    logic sel_status;
    logic [MODE_W-1:0] mode;
    logic qualify;
    logic begin_sel;
    logic begin_eff;
    logic active;
    logic a_seen;
    logic fire_raw;
    logic fire;
    logic a_step;
    logic event_only;
    logic [NUM_MATCH-1:0] raw;
    logic [DATA_W-1:0] status_word;
    trig_match_if mif ();

    assign mode = ctrl_r[MODE_LSB +: MODE_W];
    assign qualify = ctrl_r[QUAL_BIT];
    assign begin_sel = ctrl_r[BEGIN_BIT];
    assign begin_eff = begin_sel || event_only; // see RULE5
    assign active = armed_i && (state_r == SEQ_WAIT_A || state_r == SEQ_WAIT_B);
    assign a_seen = (state_r == SEQ_WAIT_B);
    assign fire = fire_raw && active;

    assign raw[M_A] = cmp_a_match_i;
    assign raw[M_B] = cmp_b_match_i;
    assign raw[M_BDATA] = cmp_b_data_match_i;
    assign raw[M_GE_A] = addr_ge_a_i;
    assign raw[M_LE_B] = addr_le_b_i;

    opcode_qualifier u_qual (
        .clk_i (clk_i),
        .arst_n_i (arst_n_i),
        .qualify_i (qualify),
        .clear_i (!armed_i),
        .access_i (access_i),
        .raw_i (raw),
        .exec_i (opcode_exec_i),
        .q (mif.src)
    );

    trig_decode u_dec (
        .mode_i (mode),
        .a_seen_i (a_seen),
        .m (mif.dst),
        .fire_o (fire_raw),
        .a_step_o (a_step),
        .event_only_o (event_only)
    );

    // APB decode
    assign setup = psel_i && !penable_i;
    assign sel_ctrl = (paddr_i == CTRL_OFFSET);
    assign sel_status = (paddr_i == STATUS_OFFSET);
    assign wr_ctrl = psel_i && penable_i && pwrite_i && sel_ctrl && pstrb_i[0];
    assign pready_o = psel_i && penable_i;
    assign prdata_o = prdata_r;
    assign pslverr_o = pready_o && pslverr_r;

    always_comb begin
        status_word = '0;
        status_word[ST_CAPTURE_BIT] = capture_r;
        status_word[ST_A_SEEN_BIT] = a_seen;
        status_word[ST_DONE_BIT] = (state_r == SEQ_DONE);
        status_word[ST_BEGIN_BIT] = begin_eff;
        status_word[ST_ARMED_BIT] = armed_i;
    end

    // Control register, frozen while armed
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ctrl_r <= CTRL_RESET;
        end else if (wr_ctrl && !armed_i) begin // see RULE1
            ctrl_r <= pwdata_i[CTRL_W-1:0] & CTRL_WMASK; // see RULE2
        end
    end

    // Read data and error latched in the setup cycle
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            prdata_r <= '0;
            pslverr_r <= 1'b0;
        end else if (setup) begin
            pslverr_r <= !(sel_ctrl || sel_status);
            if (pwrite_i) begin
                prdata_r <= '0;
            end else if (sel_ctrl) begin
                prdata_r <= {{(DATA_W-CTRL_W){1'b0}}, ctrl_r}; // see RULE1
            end else if (sel_status) begin
                prdata_r <= status_word;
            end else begin
                prdata_r <= '0;
            end
        end
    end

    // Run sequencing
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            SEQ_IDLE: begin
                if (armed_i) begin
                    state_nxt = SEQ_WAIT_A;
                end
            end
            SEQ_WAIT_A: begin
                if (!armed_i) begin
                    state_nxt = SEQ_IDLE;
                end else if (fire && !event_only) begin
                    state_nxt = SEQ_DONE;
                end else if (a_step) begin
                    state_nxt = SEQ_WAIT_B;
                end
            end
            SEQ_WAIT_B: begin
                if (!armed_i) begin
                    state_nxt = SEQ_IDLE;
                end else if (fire && !event_only) begin
                    state_nxt = SEQ_DONE;
                end
            end
            SEQ_DONE: begin
                if (!armed_i) begin
                    state_nxt = SEQ_IDLE;
                end
            end
            default: state_nxt = SEQ_IDLE;
        endcase
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_r <= SEQ_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Capture window for the trace store
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            capture_r <= 1'b0;
        end else if (!armed_i) begin
            capture_r <= 1'b0;
        end else if (state_r == SEQ_IDLE) begin
            capture_r <= !begin_eff; // see RULE4
        end else if (fire) begin
            capture_r <= begin_eff; // see RULE4
        end
    end

    // One-cycle trigger pulse
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            trigger_r <= 1'b0;
        end else begin
            trigger_r <= fire; // see RULE10
        end
    end

    assign trigger_o = trigger_r;
    assign capture_o = capture_r;
    assign begin_trace_o = begin_eff;

    sequence s_write_ctrl;
        wr_ctrl;
    endsequence

    sequence s_a_step_seen;
        active && mode == MODE_A_THEN_B && state_r == SEQ_WAIT_A && a_step;
    endsequence

    sequence s_b_after_a;
        armed_i && mode == MODE_A_THEN_B && state_r == SEQ_WAIT_B && mif.valid && mif.hit[M_B];
    endsequence

    property p_a_step;
        @(posedge clk_i) disable iff (!arst_n_i)
        s_a_step_seen |=> a_seen;
    endproperty

    property p_first_a_then_b;
        @(posedge clk_i) disable iff (!arst_n_i)
        s_b_after_a |=> trigger_o;
    endproperty

    AST_WRITE_IGNORED_ARMED: assert property (@(posedge clk_i) disable iff (!arst_n_i) // see RULE1
        s_write_ctrl and armed_i |=> $stable(ctrl_r))
        else $error("Control register changed by a write while armed");

    AST_WRITE_TAKEN: assert property (@(posedge clk_i) disable iff (!arst_n_i) // see RULE1
        s_write_ctrl and !armed_i |=> ctrl_r == ($past(pwdata_i[CTRL_W-1:0]) & CTRL_WMASK))
        else $error("Control register did not take an allowed write");

    AST_RSVD_ZERO: assert property (@(posedge clk_i) disable iff (!arst_n_i) // see RULE2
        pready_o && !pwrite_i && sel_ctrl |-> prdata_o[5:4] == 2'b00)
        else $error("Reserved control bits read back non-zero");

    AST_FORCE_PASS: assert property (@(posedge clk_i) disable iff (!arst_n_i) // see RULE3
        !qualify && access_i |-> mif.valid && mif.hit == raw)
        else $error("Force mode did not pass the access match");

    AST_TAG_WAITS: assert property (@(posedge clk_i) disable iff (!arst_n_i) // see RULE3
        qualify && !opcode_exec_i |-> !mif.valid)
        else $error("Tag mode produced a match without execution");

    AST_BEGIN_STARTS: assert property (@(posedge clk_i) disable iff (!arst_n_i) // see RULE4
        fire && begin_eff |=> capture_o || !armed_i)
        else $error("Begin trace trigger did not start capture");

    AST_END_STOPS: assert property (@(posedge clk_i) disable iff (!arst_n_i) // see RULE4
        fire && !begin_eff |=> !capture_o)
        else $error("End trace trigger did not stop capture");

    AST_EVENT_BEGIN: assert property (@(posedge clk_i) disable iff (!arst_n_i) // see RULE5
        (mode == MODE_EV_B || mode == MODE_A_THEN_EV_B) |-> begin_trace_o)
        else $error("Event-only mode not treated as begin trace");

    AST_A_ONLY: assert property (@(posedge clk_i) disable iff (!arst_n_i) // see RULE6
        active && mode == MODE_A_ONLY && mif.valid && mif.hit[M_A] |=> trigger_o)
        else $error("A-only match gave no trigger");

    AST_A_THEN_B: assert property (p_first_a_then_b) // see RULE6
        else $error("B after A gave no trigger");

    AST_A_AND_BD: assert property (@(posedge clk_i) disable iff (!arst_n_i) // see RULE7
        mode == MODE_A_AND_BD && !(mif.hit[M_A] && mif.hit[M_BDATA]) |-> !fire)
        else $error("A and B data mode fired without both matches");

    AST_IN_RANGE: assert property (@(posedge clk_i) disable iff (!arst_n_i) // see RULE8
        active && mode == MODE_IN_RANGE && mif.valid && mif.hit[M_GE_A] && mif.hit[M_LE_B] |=> trigger_o)
        else $error("Inside range access gave no trigger");

    AST_NO_TRIGGER: assert property (@(posedge clk_i) disable iff (!arst_n_i) // see RULE9
        mode > MODE_OUT_RANGE |=> !trigger_o)
        else $error("Reserved mode code produced a trigger");

    AST_PULSE: assert property (@(posedge clk_i) disable iff (!arst_n_i) // see RULE10
        trigger_o && !event_only |-> ##1 !trigger_o ##1 !trigger_o)
        else $error("Trigger pulse longer than one cycle");

    AST_A_STEP: assert property (p_a_step) // see RULE6
        else $error("A match did not move on to waiting for B");

    AST_A_OR_B: assert property (@(posedge clk_i) disable iff (!arst_n_i) // see RULE6
        active && mode == MODE_A_OR_B && mif.valid && (mif.hit[M_A] || mif.hit[M_B]) |=> trigger_o)
        else $error("A or B match gave no trigger");

    AST_A_ANDN_BD: assert property (@(posedge clk_i) disable iff (!arst_n_i) // see RULE8
        mode == MODE_A_ANDN_BD && mif.hit[M_BDATA] |-> !fire)
        else $error("A without B data mode fired on a B data match");

    AST_OUT_RANGE: assert property (@(posedge clk_i) disable iff (!arst_n_i) // see RULE8
        active && mode == MODE_OUT_RANGE && mif.valid && !(mif.hit[M_GE_A] && mif.hit[M_LE_B]) |=> trigger_o)
        else $error("Outside range access gave no trigger");

    AST_DISARM_STOPS: assert property (@(posedge clk_i) disable iff (!arst_n_i) // see RULE4
        !armed_i |=> !capture_o)
        else $error("Capture still on after disarm");

    AST_QUIET_UNARMED: assert property (@(posedge clk_i) disable iff (!arst_n_i) // see RULE10
        !armed_i |=> !trigger_o)
        else $error("Trigger pulse while not armed");
endmodule : debug_trigger_select

/* logic/opcode_qualifier.sv */
`timescale 1ns/100ps
module opcode_qualifier
    import dbg_trig_pkg::*;
(
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic qualify_i,
    input wire logic clear_i,
    input wire logic access_i,
    input wire logic [NUM_MATCH-1:0] raw_i,
    input wire logic exec_i,
    trig_match_if.src q
);
    logic [NUM_MATCH-1:0] pending_r;

    // Per-bit tag held until the opcode executes; a new tag beats the release
    genvar gi;
    generate
        for (gi = 0; gi < NUM_MATCH; gi++) begin : g_tag
            always_ff @(posedge clk_i or negedge arst_n_i) begin
                if (!arst_n_i) begin
                    pending_r[gi] <= 1'b0;
                end else if (clear_i || !qualify_i) begin
                    pending_r[gi] <= 1'b0;
                end else if (access_i && raw_i[gi]) begin // see RULE3
                    pending_r[gi] <= 1'b1;
                end else if (exec_i) begin
                    pending_r[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // Force passes the access straight on, tag waits for execution
    assign q.valid = qualify_i ? (exec_i && !clear_i) : access_i; // see RULE3
    assign q.hit = qualify_i ? pending_r : raw_i;
endmodule : opcode_qualifier

/* logic/trig_decode.sv */
`timescale 1ns/100ps
module trig_decode
    import dbg_trig_pkg::*;
(
    input wire logic [MODE_W-1:0] mode_i,
    input wire logic a_seen_i,
    trig_match_if.dst m,
    output logic fire_o,
    output logic a_step_o,
    output logic event_only_o
);
    logic a;
    logic b;
    logic bd;
    logic in_rng;

    assign a = m.hit[M_A];
    assign b = m.hit[M_B];
    assign bd = m.hit[M_BDATA];
    assign in_rng = m.hit[M_GE_A] && m.hit[M_LE_B];

    always_comb begin
        fire_o = 1'b0;
        a_step_o = 1'b0;
        event_only_o = 1'b0;
        case (mode_i)
            MODE_A_ONLY: fire_o = m.valid && a; // see RULE6
            MODE_A_OR_B: fire_o = m.valid && (a || b); // see RULE6
            MODE_A_THEN_B: begin
                fire_o = m.valid && a_seen_i && b; // see RULE6
                a_step_o = m.valid && a;
            end
            MODE_EV_B: begin
                fire_o = m.valid && b; // see RULE6
                event_only_o = 1'b1;
            end
            MODE_A_THEN_EV_B: begin
                fire_o = m.valid && a_seen_i && b; // see RULE6
                a_step_o = m.valid && a;
                event_only_o = 1'b1;
            end
            MODE_A_AND_BD: fire_o = m.valid && a && bd; // see RULE7
            MODE_A_ANDN_BD: fire_o = m.valid && a && !bd; // see RULE8
            MODE_IN_RANGE: fire_o = m.valid && in_rng; // see RULE8
            MODE_OUT_RANGE: fire_o = m.valid && !in_rng; // see RULE8
            default: fire_o = 1'b0; // see RULE9
        endcase
    end
endmodule : trig_decode

/* logic/trig_match_if.sv */
`timescale 1ns/100ps
interface trig_match_if;
    import dbg_trig_pkg::*;
    logic valid;
    logic [NUM_MATCH-1:0] hit;
    modport src (output valid, output hit);
    modport dst (input valid, input hit);
endinterface : trig_match_if

/* verif/debug_trigger_select_tb.sv */
`timescale 1ns/100ps
module debug_trigger_select_tb;
    import dbg_trig_pkg::*;
    logic clk_i, arst_n_i, psel, penable, pwrite, armed, go, exec_req;
    logic pready, pslverr, err, trig, capture, begin_trace, access, exec;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    logic [NUM_MATCH-1:0] hits, lvl;
    logic [7:0] cnt, base;
    int mismatches, checked, cyc;

    debug_trigger_select dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .armed_i(armed), .access_i(access),
        .cmp_a_match_i(lvl[M_A]), .cmp_b_match_i(lvl[M_B]), .cmp_b_data_match_i(lvl[M_BDATA]),
        .addr_ge_a_i(lvl[M_GE_A]), .addr_le_b_i(lvl[M_LE_B]), .opcode_exec_i(exec),
        .trigger_o(trig), .capture_o(capture), .begin_trace_o(begin_trace));
    match_source src (.clk_i(clk_i), .arst_n_i(arst_n_i), .go_i(go), .exec_i(exec_req), .hits_i(hits),
        .trigger_i(trig), .access_o(access), .exec_o(exec), .lvl_o(lvl), .count_o(cnt));

    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    task automatic wrap_up();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : wrap_up

    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            wrap_up();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk_i);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        do begin
            @(posedge clk_i);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic pulse(input logic [NUM_MATCH-1:0] h, input logic x);
        @(posedge clk_i);
        go <= !x;
        hits <= h;
        exec_req <= x;
        @(posedge clk_i);
        go <= 1'b0;
        exec_req <= 1'b0;
        repeat (4) @(posedge clk_i);
    endtask : pulse

    task automatic set_arm(input logic v);
        @(posedge clk_i);
        armed <= v;
        repeat (3) @(posedge clk_i);
    endtask : set_arm

    task automatic regs_basic();
        apb(1'b0, CTRL_OFFSET, 32'h0);
        check(rd, 32'h0, "ctrl reset");
        apb(1'b1, CTRL_OFFSET, 32'hffff_ffff);
        apb(1'b0, CTRL_OFFSET, 32'h0);
        check(rd, 32'h0000_00cf, "ctrl hardwired bits");
        apb(1'b0, 12'h008, 32'h0);
        check(err, 1'b1, "unmapped error");
        check(rd, 32'h0, "unmapped data");
        apb(1'b1, CTRL_OFFSET, 32'h0000_0042);
        pstrb <= 4'he;
        apb(1'b1, CTRL_OFFSET, 32'h0000_0085);
        pstrb <= 4'hf;
        apb(1'b0, CTRL_OFFSET, 32'h0);
        check(rd, 32'h0000_0042, "write without low strobe ignored");
        set_arm(1'b1);
        apb(1'b1, CTRL_OFFSET, 32'h0000_0085);
        apb(1'b0, CTRL_OFFSET, 32'h0);
        check(rd, 32'h0000_0042, "armed write ignored");
        apb(1'b0, STATUS_OFFSET, 32'h0);
        check(rd[ST_ARMED_BIT], 1'b1, "status armed");
        set_arm(1'b0);
    endtask : regs_basic

    task automatic run_mode(input logic [3:0] m);
        logic [4:0] h1, h2;
        logic [7:0] n;
        logic be;
        case (m)
            4'h0: {h1, h2, n} = {5'h01, 5'h01, 8'h01};
            4'h1: {h1, h2, n} = {5'h02, 5'h01, 8'h01};
            4'h2, 4'h4: {h1, h2, n} = {5'h01, 5'h02, 8'h01};
            4'h3: {h1, h2, n} = {5'h02, 5'h02, 8'h02};
            4'h5: {h1, h2, n} = {5'h01, 5'h05, 8'h01};
            4'h6: {h1, h2, n} = {5'h05, 5'h01, 8'h01};
            4'h7: {h1, h2, n} = {5'h08, 5'h18, 8'h01};
            4'h8: {h1, h2, n} = {5'h18, 5'h10, 8'h01};
            default: {h1, h2, n} = {5'h1f, 5'h1f, 8'h00};
        endcase
        be = m[0] | (m == 4'h3) | (m == 4'h4);
        apb(1'b1, CTRL_OFFSET, {24'h0, 1'b0, m[0], 2'b00, m});
        set_arm(1'b1);
        check(begin_trace, be, "begin select");
        check(capture, !be, "capture before trigger");
        base = cnt;
        pulse(h1, 1'b0);
        pulse(h2, 1'b0);
        check(cnt - base, n, "trigger cycles");
        check(capture, (n != 0) ? be : !be, "capture after trigger");
        set_arm(1'b0);
    endtask : run_mode

    task automatic tag_mode();
        apb(1'b1, CTRL_OFFSET, 32'h0000_00c0);
        set_arm(1'b1);
        base = cnt;
        pulse(5'h01, 1'b0);
        check(cnt - base, 8'h00, "tag before execution");
        pulse(5'h00, 1'b1);
        check(cnt - base, 8'h01, "tag on execution");
        check(capture, 1'b1, "begin trace capture");
        set_arm(1'b0);
    endtask : tag_mode

    initial begin
        {psel, penable, pwrite, armed, go, exec_req} = 6'h00;
        paddr = '0;
        pwdata = '0;
        pstrb = 4'hf;
        hits = '0;
        mismatches = 0;
        checked = 0;
        cyc = 0;
        arst_n_i = 1'b0;
        repeat (5) @(posedge clk_i);
        arst_n_i <= 1'b1;
        check({trig, capture, begin_trace}, 3'b000, "reset outputs");
        regs_basic();
        for (int i = 0; i < 16; i++) begin
            run_mode(i[3:0]);
        end
        tag_mode();
        wrap_up();
    end
endmodule : debug_trigger_select_tb

/* verif/match_source.sv */
`timescale 1ns/100ps
module match_source
    import dbg_trig_pkg::*;
(
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic go_i,
    input wire logic exec_i,
    input wire logic [NUM_MATCH-1:0] hits_i,
    input wire logic trigger_i,
    output logic access_o,
    output logic exec_o,
    output logic [NUM_MATCH-1:0] lvl_o,
    output logic [7:0] count_o
);
    logic [NUM_MATCH-1:0] last_r;
    // Levels mean nothing outside an access, so show their inverse
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            access_o <= 1'b0;
            exec_o <= 1'b0;
            lvl_o <= '0;
            last_r <= '0;
        end else begin
            access_o <= go_i;
            exec_o <= exec_i;
            last_r <= go_i ? hits_i : last_r;
            lvl_o <= go_i ? hits_i : ~last_r;
        end
    end
    // Trace store side counts cycles with the trigger high
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            count_o <= 8'h00;
        end else begin
            count_o <= count_o + {7'h00, trigger_i};
        end
    end
endmodule : match_source
